// ==== rtl/fifo_readout_pkg.sv ====
// Shared constants and carrier types for the sample FIFO readout block
package fifo_readout_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int          IDX_W     = 7;
    localparam int          DEPTH     = 128;
    localparam int          CNT_W     = 8;
    localparam int          TAG_W     = 5;
    localparam int          VAL_W     = 19;
    localparam int          ITEM_W    = 24;
    localparam int          SLOTS     = 6;
    localparam logic [4:0]  CH2_OFS   = 5'h06;  // Second channel tag offset
    localparam logic [1:0]  LAST_BYTE = 2'h2;   // Third byte of an item
    localparam logic [6:0]  IDX_MAX   = 7'h7f;
    localparam logic [6:0]  LOSS_MAX  = 7'h7f;
    localparam logic [7:0]  FULL_CNT  = 8'h80;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0]  ADDR_WR_IDX = 8'h04;
    localparam logic [7:0]  ADDR_RD_IDX = 8'h05;
    localparam logic [7:0]  ADDR_LOSS   = 8'h06;
    localparam logic [7:0]  ADDR_AVAIL  = 8'h07;
    localparam logic [7:0]  ADDR_POP    = 8'h08;
    localparam logic [7:0]  ADDR_WM     = 8'h09;
    localparam logic [7:0]  ADDR_OPT    = 8'h0a;

    // ****************************************************************
    // Option register fields and reset values
    // ****************************************************************
    localparam int          OPT_ROLL    = 1;
    localparam int          OPT_TYPE    = 2;
    localparam int          OPT_CLR     = 3;
    localparam int          OPT_FLUSH   = 4;
    localparam int          OPT_TS      = 5;
    localparam logic [7:0]  OPT_RST     = 8'h00;
    localparam logic [6:0]  WM_RST      = 7'h00;

    // ****************************************************************
    // Slot codes and tags
    // ****************************************************************
    localparam logic [3:0]  CODE_NONE   = 4'h0;
    localparam logic [3:0]  CODE_AMB    = 4'h9;
    localparam logic [4:0]  TAG_INVALID = 5'h1e;

    typedef struct packed {
        logic [4:0]  tag;
        logic [18:0] value;
    } item_t;

    typedef struct packed {
        logic [18:0] ch1_exp;
        logic [18:0] ch1_amb;
        logic [18:0] ch2_exp;
        logic [18:0] ch2_amb;
    } conv_t;

    typedef logic [5:0][3:0] slot_codes_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : fifo_readout_pkg

// ==== rtl/sample_store.sv ====
// Flip-flop item storage with one write port and one read port
`timescale 1ns/100ps
`default_nettype none
module sample_store #(
    parameter int WIDTH = fifo_readout_pkg::ITEM_W,
    parameter int IDX_W = fifo_readout_pkg::IDX_W,
    parameter int DEPTH = fifo_readout_pkg::DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [WIDTH-1:0] rd_data
);

    if (DEPTH != 2 ** IDX_W) begin : g_bad_depth
        $error("sample_store: DEPTH must be two to the IDX_W");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Store one item per write strobe
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // Read is combinational from the indexed slot
    assign rd_data = mem_q[rd_idx];

endmodule : sample_store
`default_nettype wire

// ==== rtl/slot_sequencer.sv ====
// Turns one exposure result into two tagged items in slot order
`timescale 1ns/100ps
`default_nettype none
module slot_sequencer (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          conv_valid,
    input  wire fifo_readout_pkg::conv_t       conv_data,
    input  wire fifo_readout_pkg::slot_codes_t slot_codes,
    output logic                               push_valid,
    output fifo_readout_pkg::item_t            push_item,
    output logic                               busy
);

    logic [2:0]                slot_q;
    logic                      pend_q;
    fifo_readout_pkg::item_t   pend_item_q;
    logic                      push_q;
    fifo_readout_pkg::item_t   item_q;

    // Ambient subtraction clipped at zero
    function automatic logic [18:0] sat_sub(logic [18:0] a, logic [18:0] b);
        return (a > b) ? a - b : 19'h0;
    endfunction : sat_sub

    // ****************************************************************
    // Slot decode
    // ****************************************************************
    wire logic [3:0] code     = slot_codes[slot_q];
    wire logic       direct   = code == fifo_readout_pkg::CODE_AMB;
    wire logic       take     = conv_valid && !pend_q &&
                                code != fifo_readout_pkg::CODE_NONE;
    wire logic [2:0] slot_inc = slot_q + 3'h1;
    wire logic       wrap     = slot_q == 3'(fifo_readout_pkg::SLOTS - 1) ||
                                slot_codes[slot_inc] ==
                                fifo_readout_pkg::CODE_NONE;
    wire logic [4:0] tag1     = {2'h0, slot_inc};
    wire logic [18:0] v1      = direct ? conv_data.ch1_amb :
                                sat_sub(conv_data.ch1_exp, conv_data.ch1_amb);
    wire logic [18:0] v2      = direct ? conv_data.ch2_amb :
                                sat_sub(conv_data.ch2_exp, conv_data.ch2_amb);

    // First channel item goes out next cycle, second one the cycle after
    always_ff @(posedge core_clk) begin
        if (rst) begin
            slot_q      <= 3'h0;
            pend_q      <= 1'b0;
            pend_item_q <= '0;
            push_q      <= 1'b0;
            item_q      <= '0;
        end else begin
            push_q <= take || pend_q;
            pend_q <= take;
            if (take) begin
                item_q      <= '{tag: tag1, value: v1};
                pend_item_q <= '{tag: tag1 + fifo_readout_pkg::CH2_OFS,
                                 value: v2};
                slot_q      <= wrap ? 3'h0 : slot_inc;
            end else if (pend_q) begin
                item_q <= pend_item_q;
            end
        end
    end

    assign push_valid = push_q;
    assign push_item  = item_q;
    assign busy       = pend_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_second_tag: assert property (take |=> ##1 push_valid &&
        push_item.tag == $past(tag1, 2) + 5'h06)
        else $error("second channel tag is not slot plus six");
    chk_pair_order: assert property (take |=> push_valid &&
        push_item.tag == $past(tag1) ##1 push_valid)
        else $error("first channel item not followed by second");

endmodule : slot_sequencer
`default_nettype wire

// ==== rtl/optical_sample_fifo_readout.sv ====
// Sample FIFO with host readout registers for an optical front end
//
// Contract
// - Seven-bit write index, wraps 7F to 00
// - Seven-bit read index, advances per item read
// - Host may read and rewrite read index
// - Loss counter counts lost items, holds 7F
// - Item pop clears loss counter
// - Available count up on push, down on read
// - Three-byte burst at pop port advances index
// - Items stored slot by slot, channel one first
// - Tags are slot and slot plus six
// - LED slots corrected, direct ambient raw
// - Two items of three bytes per slot
// - Value left-justified below the tag
// - Tag occupies item bits 23 to 19
// - Almost-full when count reaches 128 minus watermark
// - Roll-over overwrites oldest, else new item dropped
// - Flush clears indices, count and loss counter
// - Flag type picks repeated or new-only assertion
`timescale 1ns/100ps
`default_nettype none
module optical_sample_fifo_readout (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire fifo_readout_pkg::reg_req_t    reg_req,
    input  wire logic                          frame_active,
    output logic [7:0]                         reg_rdata,
    input  wire logic                          conv_valid,
    input  wire fifo_readout_pkg::conv_t       conv_data,
    input  wire fifo_readout_pkg::slot_codes_t slot_codes,
    output logic                               conv_busy,
    input  wire logic                          status_clear,
    output logic                               almost_full
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [6:0]              wr_q;
    logic [6:0]              rd_q;
    logic [7:0]              count_q;
    logic [6:0]              loss_q;
    logic [6:0]              wm_q;
    logic [7:0]              opt_q;
    logic [1:0]              byte_q;
    logic                    cond_q;
    logic                    af_q;
    logic [7:0]              rdata_q;
    logic                    push;
    fifo_readout_pkg::item_t push_item;
    logic [23:0]             store_rd;
    logic                    write_slot;

    // ****************************************************************
    // Item producer and storage
    // ****************************************************************
    slot_sequencer u_seq (
        .core_clk   (core_clk),
        .rst        (rst),
        .conv_valid (conv_valid),
        .conv_data  (conv_data),
        .slot_codes (slot_codes),
        .push_valid (push),
        .push_item  (push_item),
        .busy       (conv_busy)
    );

    sample_store #(
        .WIDTH (fifo_readout_pkg::ITEM_W),
        .IDX_W (fifo_readout_pkg::IDX_W),
        .DEPTH (fifo_readout_pkg::DEPTH)
    ) u_store (
        .core_clk (core_clk),
        .wr_en    (write_slot),
        .wr_idx   (wr_q),
        .wr_data  (push_item),
        .rd_idx   (rd_q),
        .rd_data  (store_rd)
    );

    // ****************************************************************
    // Host access decode
    // ****************************************************************
    wire logic [7:0] addr     = reg_req.addr;
    wire logic       data_rd  = reg_req.rd && addr == fifo_readout_pkg::ADDR_POP;
    wire logic       rd_set   = reg_req.wr &&
                                addr == fifo_readout_pkg::ADDR_RD_IDX;
    wire logic       wm_set   = reg_req.wr && addr == fifo_readout_pkg::ADDR_WM;
    wire logic       opt_set  = reg_req.wr && addr == fifo_readout_pkg::ADDR_OPT;
    wire logic       flush    = opt_set &&
                                reg_req.wdata[fifo_readout_pkg::OPT_FLUSH];
    wire logic       empty    = count_q == 8'h00;
    wire logic       full     = count_q == fifo_readout_pkg::FULL_CNT;
    wire logic       pop      = data_rd && !empty &&
                                byte_q == fifo_readout_pkg::LAST_BYTE;
    wire logic       roll_en  = opt_q[fifo_readout_pkg::OPT_ROLL];
    wire logic       type_new = opt_q[fifo_readout_pkg::OPT_TYPE];
    wire logic       clr_pop  = opt_q[fifo_readout_pkg::OPT_CLR];

    // ****************************************************************
    // Push classification
    // ****************************************************************
    wire logic accept     = push && !flush && (!full || pop);
    wire logic roll       = push && !flush && full && !pop && roll_en;
    wire logic drop       = push && !flush && full && !pop && !roll_en;
    assign     write_slot = accept || roll;
    wire logic lost       = roll || drop;

    // ****************************************************************
    // Next values for indices and counters
    // ****************************************************************
    wire logic [6:0] new_rd  = reg_req.wdata[6:0];
    wire logic [6:0] set_gap = wr_q - new_rd;
    wire logic [7:0] set_cnt = (set_gap == 7'h00 && full) ? count_q :
                               {1'b0, set_gap};
    wire logic [6:0] wr_d    = flush      ? 7'h00 :
                               write_slot ? wr_q + 7'h01 : wr_q;
    wire logic [6:0] rd_d    = flush      ? 7'h00 :
                               rd_set     ? new_rd :
                               (pop || roll) ? rd_q + 7'h01 : rd_q;
    wire logic [7:0] count_d = flush  ? 8'h00 :
                               rd_set ? set_cnt :
                               count_q + {7'h00, accept} - {7'h00, pop};
    wire logic [6:0] loss_d  = flush ? 7'h00 :
                               pop   ? 7'h00 :
                               (lost && loss_q != fifo_readout_pkg::LOSS_MAX) ?
                               loss_q + 7'h01 : loss_q;

    // ****************************************************************
    // Almost-full detection
    // ****************************************************************
    wire logic [7:0] thresh  = fifo_readout_pkg::FULL_CNT - {1'b0, wm_q};
    wire logic       cond_d  = count_d >= thresh;
    wire logic       af_set  = write_slot && cond_d &&
                               (!type_new || !cond_q);
    wire logic       af_clr  = status_clear || (clr_pop && data_rd);

    // ****************************************************************
    // Read data selection
    // ****************************************************************
    wire logic [23:0] out_item = empty ?
                                 {fifo_readout_pkg::TAG_INVALID, 19'h0} :
                                 store_rd;
    wire logic [7:0]  pop_byte = byte_q == 2'h0 ? out_item[23:16] :
                                 byte_q == 2'h1 ? out_item[15:8] :
                                 out_item[7:0];
    wire logic [7:0]  rdata_d  =
        addr == fifo_readout_pkg::ADDR_WR_IDX ? {1'b0, wr_q} :
        addr == fifo_readout_pkg::ADDR_RD_IDX ? {1'b0, rd_q} :
        addr == fifo_readout_pkg::ADDR_LOSS   ? {1'b0, loss_q} :
        addr == fifo_readout_pkg::ADDR_AVAIL  ? count_q :
        addr == fifo_readout_pkg::ADDR_POP    ? pop_byte :
        addr == fifo_readout_pkg::ADDR_WM     ? {1'b0, wm_q} :
        addr == fifo_readout_pkg::ADDR_OPT    ? opt_q : 8'h00;

    // Byte position inside the current burst
    wire logic [1:0]  byte_d   = !frame_active ? 2'h0 :
                                 (data_rd && !empty) ?
                                 (pop ? 2'h0 : byte_q + 2'h1) : byte_q;

    // Index and counter registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_q    <= 7'h00;
            rd_q    <= 7'h00;
            count_q <= 8'h00;
            loss_q  <= 7'h00;
            byte_q  <= 2'h0;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            count_q <= count_d;
            loss_q  <= loss_d;
            byte_q  <= byte_d;
        end
    end

    // Configuration registers; the flush bit never stores
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wm_q  <= fifo_readout_pkg::WM_RST;
            opt_q <= fifo_readout_pkg::OPT_RST;
        end else begin
            if (wm_set) begin
                wm_q <= reg_req.wdata[6:0];
            end
            if (opt_set) begin
                opt_q <= {2'h0, reg_req.wdata[5], 1'b0,
                          reg_req.wdata[3:1], 1'b0};
            end
        end
    end

    // Flag and read data; a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cond_q  <= 1'b0;
            af_q    <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            cond_q <= cond_d;
            if (af_set) begin
                af_q <= 1'b1;
            end else if (af_clr) begin
                af_q <= 1'b0;
            end
            if (reg_req.rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata   = rdata_q;
    assign almost_full = af_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Indices, counters and almost-full flag
    chk_wr_advance: assert property (write_slot && !flush |=>
        wr_q == 7'($past(wr_q) + 7'h01))
        else $error("write index did not advance by one");
    chk_rd_wrap: assert property (pop && rd_q == 7'h7f |=>
        rd_q == 7'h00)
        else $error("read index did not wrap to zero");
    chk_rd_host_set: assert property (rd_set && !flush |=>
        rd_q == $past(new_rd))
        else $error("host read index write not taken");
    chk_loss_hold: assert property (loss_q == 7'h7f && !pop && !flush |=>
        loss_q == 7'h7f)
        else $error("loss counter left saturation");
    chk_loss_clear: assert property (pop |=> loss_q == 7'h00)
        else $error("loss counter not cleared by pop");
    chk_count_up: assert property (accept && !pop && !rd_set |=>
        count_q == 8'($past(count_q) + 8'h01))
        else $error("available count did not increment");
    chk_burst_pop: assert property ((data_rd && !empty && frame_active &&
        !rd_set && !flush)[*3] |-> ##1 rd_q != $past(rd_q, 3) || $past(roll))
        else $error("three byte burst did not advance read index");
    chk_drop_keeps: assert property (drop && !rd_set |=>
        wr_q == $past(wr_q) && $stable(count_q))
        else $error("dropped item changed the FIFO");
    chk_flush_all: assert property (flush |=> wr_q == 7'h00 &&
        rd_q == 7'h00 && count_q == 8'h00 && loss_q == 7'h00)
        else $error("flush left state behind");
    chk_empty_read: assert property (data_rd && empty && !flush |=>
        $stable(rd_q) && $stable(loss_q))
        else $error("empty read moved the read index");
    chk_af_raise: assert property (af_set |=> almost_full [*1])
        else $error("almost full flag not raised");
    chk_af_new_only: assert property (type_new && cond_q &&
        !almost_full |=> !almost_full)
        else $error("flag re-raised on a standing condition");
    chk_af_repeat: assert property (!type_new && write_slot &&
        cond_d |=> almost_full)
        else $error("flag not re-raised on a standing condition");
    chk_af_clear: assert property (af_clr && !af_set |=>
        !almost_full)
        else $error("almost full flag not cleared");

    // Index movement
    chk_wr_wrap: assert property (write_slot && wr_q == 7'h7f |=>
        wr_q == 7'h00)
        else $error("write index did not wrap to zero");
    chk_rd_advance: assert property (pop |=>
        rd_q == 7'($past(rd_q) + 7'h01))
        else $error("pop did not advance the read index");
    chk_roll_keeps: assert property (roll && !rd_set |=>
        $stable(count_q) && rd_q == 7'($past(rd_q) + 7'h01))
        else $error("roll-over did not drop the oldest item");

    // Counters and burst position
    chk_count_down: assert property (pop && !accept |=>
        count_q == 8'($past(count_q) - 8'h01))
        else $error("available count did not decrement");
    chk_loss_count: assert property (lost && loss_q != 7'h7f |=>
        loss_q == 7'($past(loss_q) + 7'h01))
        else $error("lost item not counted");
    chk_empty_count: assert property (data_rd && empty &&
        !push |=> $stable(count_q))
        else $error("empty read changed the count");
    chk_byte_restart: assert property (!frame_active |=>
        byte_q == 2'h0)
        else $error("burst position kept across frames");

    // Coverage of the main scenarios
    cov_roll: cover property (roll ##1 pop);
    cov_drop: cover property (drop);
    cov_burst: cover property (data_rd [*3] ##0 pop);
    cov_flush: cover property (flush && !empty);
    cov_af_new: cover property (type_new && af_set);

endmodule : optical_sample_fifo_readout
`default_nettype wire

// ==== tb/host_model.sv ====
// Host processor model driving the block's register access protocol
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic                  core_clk,
    output fifo_readout_pkg::reg_req_t reg_req,
    output logic                       frame_active,
    input  wire logic [7:0]            reg_rdata
);
    // ****************************************************************
    // Register access tasks
    // ****************************************************************
    initial begin
        reg_req = '0;
        frame_active = 1'b0;
    end

    // Idle bus: address and data inverted so stale values never match
    task automatic release_bus;
        reg_req.rd = 1'b0;
        reg_req.wr = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
        frame_active = 1'b0;
    endtask : release_bus

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        frame_active = 1'b1;
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(posedge core_clk) #1;
        release_bus();
    endtask : reg_write

    // Read strobe held for n bytes in one frame, bytes shifted in
    task automatic burst(input logic [7:0] a, input int n,
                         output logic [23:0] d);
        d = '0;
        @(posedge core_clk) #1;
        frame_active = 1'b1;
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk) #1;
            d = {d[15:0], reg_rdata};
        end
        release_bus();
    endtask : burst

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic [23:0] w;
        burst(a, 1, w);
        d = w[7:0];
    endtask : reg_read

    task automatic pop_item(output logic [23:0] d);
        burst(fifo_readout_pkg::ADDR_POP, 3, d);
    endtask : pop_item
endmodule : host_model
`default_nettype wire

// ==== tb/optical_sample_fifo_readout_tb_top.sv ====
// Self-checking testbench for the sample FIFO readout block
`timescale 1ns/100ps
`default_nettype none
module optical_sample_fifo_readout_tb_top;
    logic                          core_clk;
    logic                          rst;
    fifo_readout_pkg::reg_req_t    reg_req;
    logic                          frame_active;
    logic [7:0]                    reg_rdata;
    logic                          conv_valid;
    fifo_readout_pkg::conv_t       conv_data;
    fifo_readout_pkg::slot_codes_t slot_codes;
    logic                          conv_busy;
    logic                          status_clear;
    logic                          almost_full;
    int                            n_fail;
    int                            n_checks;
    int                            n_conv;
    fifo_readout_pkg::item_t       exp_q[$];
    logic [7:0]                    b;
    logic [23:0]                   w;
    logic [7:0]                    ra[5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a};

    // ****************************************************************
    // Clock, instances and tasks
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    optical_sample_fifo_readout uut (.core_clk(core_clk), .rst(rst),
        .reg_req(reg_req), .frame_active(frame_active),
        .reg_rdata(reg_rdata), .conv_valid(conv_valid),
        .conv_data(conv_data), .slot_codes(slot_codes),
        .conv_busy(conv_busy), .status_clear(status_clear),
        .almost_full(almost_full));

    host_model host (.core_clk(core_clk), .reg_req(reg_req),
        .frame_active(frame_active), .reg_rdata(reg_rdata));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_item(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: item %h expected %h", $time, got, exp);
        end
    endtask : chk_item

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.reg_read(a, b);
        chk(b, exp);
    endtask : rd_chk

    // Pulse conversions two cycles apart and predict the stored items
    task automatic convert(input int n);
        logic [3:0]  code;
        logic [18:0] e1;
        logic [4:0]  t;
        for (int i = 0; i < n; i++) begin
            code = slot_codes[n_conv % 3];
            e1 = 19'h40000 + 19'(n_conv);
            t = 5'(n_conv % 3 + 1);
            @(posedge core_clk) #1;
            conv_data = {e1, 19'h00100, 19'h00050, 19'h00080};
            conv_valid = 1'b1;
            if (code == fifo_readout_pkg::CODE_AMB) begin
                exp_q.push_back({t, 19'h00100});
                exp_q.push_back({t + 5'h06, 19'h00080});
            end else begin
                exp_q.push_back({t, e1 - 19'h00100});
                exp_q.push_back({t + 5'h06, 19'h00000});
            end
            n_conv++;
            @(posedge core_clk) #1;
            chk({7'h00, conv_busy}, 8'h01);
            conv_valid = 1'b0;
        end
        repeat (2) @(posedge core_clk);
        #1;
    endtask : convert

    task automatic clear_flag;
        @(posedge core_clk) #1;
        status_clear = 1'b1;
        @(posedge core_clk) #1;
        status_clear = 1'b0;
    endtask : clear_flag

    task automatic end_of_test;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (50000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        n_fail = 0;
        n_checks = 0;
        n_conv = 0;
        rst = 1'b1;
        conv_valid = 1'b0;
        conv_data = '0;
        status_clear = 1'b0;
        slot_codes = {4'h0, 4'h0, 4'h0, 4'h9, 4'h2, 4'h1};
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        foreach (ra[i]) rd_chk(ra[i], 8'h00);
        rd_chk(8'h0b, 8'h00);
        host.pop_item(w);
        chk_item(w, 24'hf0f0f0);
        for (int i = 1; i < 4; i++) rd_chk(ra[i], 8'h00);
        convert(3);
        rd_chk(8'h04, 8'h06);
        rd_chk(8'h07, 8'h06);
        for (int i = 0; i < 6; i++) begin
            host.pop_item(w);
            chk_item(w, exp_q[i]);
        end
        rd_chk(8'h05, 8'h06);
        rd_chk(8'h07, 8'h00);
        host.reg_write(8'h05, 8'h01);
        host.reg_write(8'h07, 8'hff);
        rd_chk(8'h07, 8'h05);
        host.pop_item(w);
        chk_item(w, exp_q[1]);
        host.reg_write(8'h0a, 8'h10);
        foreach (ra[i]) rd_chk(ra[i], 8'h00);
        host.reg_write(8'h09, 8'h7e);
        convert(1);
        chk({7'h00, almost_full}, 8'h01);
        clear_flag();
        convert(1);
        chk({7'h00, almost_full}, 8'h01);
        host.reg_write(8'h0a, 8'h04);
        clear_flag();
        convert(1);
        chk({7'h00, almost_full}, 8'h00);
        host.reg_write(8'h0a, 8'h10);
        convert(64);
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h07, 8'h80);
        convert(1);
        rd_chk(8'h06, 8'h02);
        rd_chk(8'h04, 8'h00);
        host.reg_write(8'h0a, 8'h02);
        convert(1);
        rd_chk(8'h05, 8'h02);
        rd_chk(8'h04, 8'h02);
        convert(62);
        rd_chk(8'h06, 8'h7f);
        host.reg_read(8'h07, b);
        chk(b, 8'h80);
        rd_chk(8'h05, 8'h7e);
        host.reg_write(8'h0a, 8'h0a);
        host.pop_item(w);
        chk({7'h00, almost_full}, 8'h00);
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h07, 8'h7f);
        host.pop_item(w);
        rd_chk(8'h05, 8'h00);
        end_of_test();
    end
endmodule : optical_sample_fifo_readout_tb_top
`default_nettype wire
